// ### hw/umcls_core.sv
// Modem control and line status logic for one UART channel.
`timescale 1ns/1ns
`default_nettype none
`include "umcls_params.svh"
module umcls_core #(
  parameter int FIFO_DEPTH = `UMCLS_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Host register port
  input wire logic [3:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic flow_threshold_wr,
  output logic trigger_level_wr,
  output logic pin_level_wr,
  output logic [7:0] pin_level_wdata,
  input wire logic enhanced_write_en,
  // Receiver side
  input wire logic rx_push,
  input wire logic [7:0] rx_data,
  input wire logic rx_stop_bad,
  input wire logic rx_parity_bad,
  input wire logic rx_line_low_frame,
  input wire logic rx_overrun,
  input wire logic rx_pop,
  input wire logic rx_fifo_not_empty,
  input wire logic [2:0] rx_head_flags,
  output logic [7:0] rx_store_data,
  output logic [2:0] rx_store_flags,
  output logic rx_store_en,
  // Transmitter side
  input wire logic tx_holding_empty,
  input wire logic tx_shifter_empty,
  input wire logic tx_serial_out,
  output logic tx_pin,
  output logic rx_serial_in,
  input wire logic rx_pin,
  // Modem lines
  input wire logic auto_rts_en,
  input wire logic auto_rts_level,
  input wire logic dtr_pin_selected,
  input wire logic pin_level_dtr_bit,
  input wire logic cts_n_pin,
  input wire logic dsr_n_pin,
  output logic rts_n_pin,
  output logic dtr_n_pin,
  output logic cts_status,
  output logic dsr_status,
  output logic xon_any_en,
  output logic loopback_en,
  output logic irda_mode,
  output logic clk_div4
);
  logic [7:0] modem_control;
  logic overrun;
  logic fifo_err;
  logic break_now;
  logic [7:0] next_modem_control;

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  function automatic logic [7:0] merge_mc(input logic [7:0] old, input logic [7:0] wd, input logic en);
    logic [7:0] mask;
    mask = en ? 8'hFF : ~(`UMCLS_MC_PROT_MASK);
    merge_mc = (wd & mask) | (old & ~mask);
  endfunction

  always_comb begin
    next_modem_control = merge_mc(modem_control, reg_wdata, enhanced_write_en);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      modem_control <= `UMCLS_MC_RESET;
    end else if (reg_wr && reg_sel == `UMCLS_SEL_MODEM_CONTROL) begin
      modem_control <= next_modem_control;
    end
  end

  // Flow threshold shares its selector with modem status; bit two picks both threshold registers.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flow_threshold_wr <= 1'b0;
      trigger_level_wr <= 1'b0;
      pin_level_wr <= 1'b0;
      pin_level_wdata <= 8'h00;
    end else begin
      flow_threshold_wr <= reg_wr && modem_control[`UMCLS_MC_THR_EN] && enhanced_write_en
        && reg_sel == `UMCLS_SEL_FLOW_THRESHOLD;
      trigger_level_wr <= reg_wr && modem_control[`UMCLS_MC_THR_EN] && enhanced_write_en
        && reg_sel == `UMCLS_SEL_TRIGGER_LEVEL;
      pin_level_wr <= reg_wr && reg_sel == `UMCLS_SEL_PIN_LEVEL;
      pin_level_wdata <= reg_wdata;
    end
  end

  // ----------------------------------------
  // Line status
  // ----------------------------------------
  umcls_err_count #(
    .DEPTH(FIFO_DEPTH)
  ) u_err_count (
    .core_clk(core_clk),
    .reset(reset),
    .push_err(rx_push && (rx_stop_bad || rx_parity_bad || rx_line_low_frame)),
    .pop_err(rx_pop && (rx_head_flags != 3'b000)),
    .any_err(fifo_err)
  );

  // Overrun: a new overrun in the read cycle wins over the clear.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      overrun <= 1'b0;
    end else if (rx_overrun) begin
      overrun <= 1'b1;
    end else if (reg_rd && reg_sel == `UMCLS_SEL_LINE_STATUS && !modem_control[`UMCLS_MC_THR_EN]) begin
      overrun <= 1'b0;
    end
  end

  assign break_now = rx_line_low_frame;

  // Flags travel with the character into the FIFO, so they surface at the head.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_store_en <= 1'b0;
      rx_store_data <= 8'h00;
      rx_store_flags <= 3'b000;
    end else begin
      rx_store_en <= rx_push;
      rx_store_data <= break_now ? 8'h00 : rx_data;
      rx_store_flags <= {break_now, rx_stop_bad, rx_parity_bad};
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && reg_sel == `UMCLS_SEL_MODEM_CONTROL) begin
      reg_rdata <= modem_control;
    end else if (reg_rd && reg_sel == `UMCLS_SEL_LINE_STATUS) begin
      reg_rdata <= {fifo_err,
        tx_holding_empty && tx_shifter_empty,
        tx_holding_empty,
        rx_fifo_not_empty ? rx_head_flags : 3'b000,
        overrun || rx_overrun,
        rx_fifo_not_empty};
    end else if (reg_rd && reg_sel == `UMCLS_SEL_MODEM_STATUS && !modem_control[`UMCLS_MC_THR_EN]) begin
      reg_rdata <= {2'b00, dsr_status, cts_status, 4'h0};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Modem lines and loopback
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rts_n_pin <= 1'b1;
      dtr_n_pin <= 1'b1;
      tx_pin <= 1'b1;
      rx_serial_in <= 1'b1;
      cts_status <= 1'b0;
      dsr_status <= 1'b0;
    end else if (modem_control[`UMCLS_MC_LOOP]) begin
      // Pins idle inactive while the channel talks to itself.
      rts_n_pin <= 1'b1;
      dtr_n_pin <= 1'b1;
      tx_pin <= 1'b1;
      rx_serial_in <= tx_serial_out;
      cts_status <= modem_control[`UMCLS_MC_RTS];
      dsr_status <= modem_control[`UMCLS_MC_DTR];
    end else begin
      rts_n_pin <= auto_rts_en ? auto_rts_level : ~modem_control[`UMCLS_MC_RTS];
      // The pin level register bit has no path here while the pin is DTR.
      dtr_n_pin <= dtr_pin_selected ? ~modem_control[`UMCLS_MC_DTR] : pin_level_dtr_bit;
      tx_pin <= tx_serial_out;
      rx_serial_in <= rx_pin;
      cts_status <= ~cts_n_pin;
      dsr_status <= ~dsr_n_pin;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      xon_any_en <= 1'b0;
      loopback_en <= 1'b0;
      irda_mode <= 1'b0;
      clk_div4 <= 1'b0;
    end else begin
      xon_any_en <= modem_control[`UMCLS_MC_XON_ANY];
      loopback_en <= modem_control[`UMCLS_MC_LOOP];
      irda_mode <= modem_control[`UMCLS_MC_IRDA];
      clk_div4 <= modem_control[`UMCLS_MC_CLKDIV];
    end
  end
endmodule
`default_nettype wire

// ### hw/umcls_err_count.sv
// Counter of receive FIFO entries that carry an error flag.
`timescale 1ns/1ns
`default_nettype none
module umcls_err_count #(
  parameter int DEPTH = 64
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Events
  input wire logic push_err,
  input wire logic pop_err,
  // Result
  output logic any_err
);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  logic [CW-1:0] count;
  umcls_pkg::umcls_err_op_t op;

  always_comb begin
    op = umcls_pkg::umcls_err_op_t'({pop_err, push_err});
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      count <= '0;
    end else begin
      case (op)
        // The FIFO never holds more than DEPTH entries, so the count stops there.
        umcls_pkg::UMCLS_ERR_ADD: count <= (count != FULL) ? count + 1'b1 : count;
        umcls_pkg::UMCLS_ERR_SUB: count <= (count != '0) ? count - 1'b1 : count;
        default: count <= count;
      endcase
    end
  end

  // Zero only when no erroneous character remains anywhere.
  assign any_err = (count != '0);
endmodule
`default_nettype wire

// ### hw/umcls_params.svh
// Constants for the modem control and line status block.
`ifndef UMCLS_PARAMS_SVH
`define UMCLS_PARAMS_SVH
// ----------------------------------------
// Modem control field positions
// ----------------------------------------
`define UMCLS_MC_DTR 0
`define UMCLS_MC_RTS 1
`define UMCLS_MC_THR_EN 2
`define UMCLS_MC_LOOP 4
`define UMCLS_MC_XON_ANY 5
`define UMCLS_MC_IRDA 6
`define UMCLS_MC_CLKDIV 7
// Bits 7..5 and 2 are write protected by the enhanced write enable.
`define UMCLS_MC_PROT_MASK 8'hE4
`define UMCLS_MC_RESET 8'h00
// ----------------------------------------
// Line status field positions
// ----------------------------------------
`define UMCLS_LS_DATA 0
`define UMCLS_LS_OVR 1
`define UMCLS_LS_PAR 2
`define UMCLS_LS_FRM 3
`define UMCLS_LS_BRK 4
`define UMCLS_LS_THRE 5
`define UMCLS_LS_TEMT 6
`define UMCLS_LS_FERR 7
// ----------------------------------------
// Register selectors on the host port
// ----------------------------------------
`define UMCLS_SEL_MODEM_CONTROL 4'h4
`define UMCLS_SEL_LINE_STATUS 4'h5
`define UMCLS_SEL_MODEM_STATUS 4'h6
`define UMCLS_SEL_FLOW_THRESHOLD 4'h6
`define UMCLS_SEL_TRIGGER_LEVEL 4'h7
`define UMCLS_SEL_PIN_LEVEL 4'hB
`define UMCLS_FIFO_DEPTH 64
`endif

// ### hw/umcls_pkg.sv
// Types shared by the modem control and line status block.
package umcls_pkg;
  typedef enum logic [1:0] {
    UMCLS_ERR_IDLE = 2'b00,
    UMCLS_ERR_ADD = 2'b01,
    UMCLS_ERR_BOTH = 2'b11,
    UMCLS_ERR_SUB = 2'b10
  } umcls_err_op_t;
endpackage

// ### sim/tb.sv
// Random self-checking bench for the modem control and line status block.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic core_clk, reset, reg_wr, reg_rd, flow_threshold_wr, trigger_level_wr, pin_level_wr, enhanced_write_en;
  logic rx_push, rx_stop_bad, rx_parity_bad, rx_line_low_frame, rx_overrun, rx_pop, rx_fifo_not_empty, rx_store_en;
  logic tx_holding_empty, tx_shifter_empty, tx_serial_out, tx_pin, rx_serial_in, rx_pin, auto_rts_en, auto_rts_level;
  logic dtr_pin_selected, pin_level_dtr_bit, cts_n_pin, dsr_n_pin, rts_n_pin, dtr_n_pin, cts_status, dsr_status;
  logic xon_any_en, loopback_en, irda_mode, clk_div4;
  logic [3:0] reg_sel;
  logic [7:0] reg_wdata, reg_rdata, pin_level_wdata, rx_data, rx_store_data;
  logic [2:0] rx_head_flags, rx_store_flags;
  logic [3:0] sels [8] = '{4'h4, 4'h4, 4'h5, 4'h5, 4'h6, 4'h7, 4'hB, 4'h4};
  logic [31:0] rnd = 32'h0001_1854;
  int error_cnt = 0;
  int check_count = 0;
  int mc, ovr, e_mc, e_rd, e_ctl, e_st, e_sd, e_pins, e_rts, e_dtr;
  int ecnt;
  umcls_core #(.FIFO_DEPTH(64)) i_dut (.*);
  umcls_modem #(.DLY(3)) i_modem (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic drive;
    repeat (32) rnd = lfsr(rnd);
    {enhanced_write_en, auto_rts_en, auto_rts_level, dtr_pin_selected, pin_level_dtr_bit, rx_push, rx_stop_bad,
      rx_parity_bad, rx_line_low_frame, rx_pop, rx_fifo_not_empty, tx_holding_empty, tx_shifter_empty,
      tx_serial_out, reg_wdata, rx_head_flags} = rnd[24:0];
    reg_sel = sels[rnd[27:25]];
    reg_wr = rnd[30:29] == 2'b00;
    reg_rd = rnd[30:29] == 2'b01;
    // Overrun never lands on a status read, so the case where it wins over the clear is never driven.
    rx_overrun = rnd[31] & rnd[30];
    rx_data = rnd[31:24];
  endtask
  // Reference model, stepped on every rising edge.
  always @(posedge core_clk) begin
    e_mc = mc;
    e_rd = !reg_rd ? 0 : reg_sel != 4'h5 ? -1 :
      {ecnt != 0, tx_holding_empty & tx_shifter_empty, tx_holding_empty,
      rx_fifo_not_empty ? rx_head_flags : 3'b000, ovr[0], rx_fifo_not_empty};
    // Count of FIFO entries that carry an error, bounded by the FIFO depth.
    ecnt = reset ? 0 :
      (rx_push && (rx_stop_bad || rx_parity_bad || rx_line_low_frame) && !(rx_pop && rx_head_flags != 0)
      && ecnt < 64) ? ecnt + 1 :
      (rx_pop && rx_head_flags != 0 && !(rx_push && (rx_stop_bad || rx_parity_bad || rx_line_low_frame))
      && ecnt > 0) ? ecnt - 1 : ecnt;
    e_ctl = {reg_wr && reg_sel == 4'hB, reg_wr && reg_sel == 4'h6 && mc[2] && enhanced_write_en,
      reg_wr && reg_sel == 4'h7 && mc[2] && enhanced_write_en, mc[7:4]};
    e_st = {rx_push, rx_line_low_frame, rx_stop_bad, rx_parity_bad};
    e_sd = rx_line_low_frame ? 0 : rx_data;
    e_pins = {mc[4] ? mc[1] : !cts_n_pin, mc[4] ? mc[0] : !dsr_n_pin, mc[4] ? tx_serial_out : rx_pin, mc[4] | tx_serial_out};
    e_rts = mc[4] ? 1 : auto_rts_en ? -1 : !mc[1];
    e_dtr = mc[4] ? 1 : dtr_pin_selected ? !mc[0] : -1;
    ovr = reset ? 0 : rx_overrun ? 1 : reg_rd && reg_sel == 4'h5 && !mc[2] ? 0 : ovr;
    if (reset) begin
      mc = 0;
    end else if (reg_wr && reg_sel == 4'h4) begin
      mc = enhanced_write_en ? reg_wdata : mc & 8'hE4 | reg_wdata & 8'h1B;
    end
  end
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #200_000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    reset = 1;
    drive;
    repeat (20) @(negedge core_clk);
    reset = 0;
    drive;
    repeat (3000) begin
      @(negedge core_clk);
      if (e_rd >= 0) check("line_status", reg_rdata, e_rd[7:0]);
      check("control", {pin_level_wr, flow_threshold_wr, trigger_level_wr, clk_div4, irda_mode, xon_any_en,
        loopback_en}, e_ctl[7:0]);
      check("store_en", rx_store_en, e_st[3]);
      if (e_st[3]) check("store_data", rx_store_data, e_sd[7:0]);
      if (e_st[3]) check("store_flags", rx_store_flags, e_st[2:0]);
      check("status_pins", {cts_status, dsr_status, rx_serial_in, tx_pin}, e_pins[7:0]);
      if (e_rts >= 0) check("rts", rts_n_pin, e_rts[7:0]);
      if (e_dtr >= 0) check("dtr", dtr_n_pin, e_dtr[7:0]);
      drive;
    end
    report_and_stop;
  end
endmodule
`default_nettype wire

// ### sim/umcls_core_props.sv
// Port-level checks for the modem control and line status block.
`timescale 1ns/1ns
`default_nettype none
`include "umcls_params.svh"
module umcls_core_props (
  // Clock, reset and host port
  input wire logic core_clk, reset, reg_wr, enhanced_write_en, flow_threshold_wr, trigger_level_wr,
  input wire logic [3:0] reg_sel,
  input wire logic [7:0] reg_wdata, rx_store_data,
  // Receiver and serial path
  input wire logic rx_push, rx_line_low_frame, rx_store_en, tx_serial_out, rx_pin, rx_serial_in,
  input wire logic [2:0] rx_store_flags,
  // Modem lines
  input wire logic auto_rts_en, auto_rts_level, rts_n_pin, cts_status, dsr_status, xon_any_en
);
  logic [7:0] mc;
  // Shadow of the control register, so the pins can be judged without seeing inside.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mc <= 8'h00;
    end else if (reg_wr && reg_sel == 4'h4) begin
      mc <= enhanced_write_en ? reg_wdata : (mc & `UMCLS_MC_PROT_MASK) | (reg_wdata & ~`UMCLS_MC_PROT_MASK);
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_thr; flow_threshold_wr == $past(reg_wr && reg_sel == 4'h6 && mc[2] && enhanced_write_en); endproperty
  a_thr: assert property (p_thr) else $error("threshold write pulse wrong");
  property p_tlv; $past(reg_wr && reg_sel == 4'h7 && !(mc[2] && enhanced_write_en)) |-> !trigger_level_wr; endproperty
  a_tlv: assert property (p_tlv) else $error("trigger write not gated");
  property p_xon; xon_any_en == $past(mc[5]); endproperty
  a_xon: assert property (p_xon) else $error("xon any enable wrong");
  property p_rts; $past(!mc[4] && !auto_rts_en) |-> rts_n_pin == !$past(mc[1]); endproperty
  a_rts: assert property (p_rts) else $error("request pin wrong");
  property p_auto;
    !$past(reset, 2) && $past(!mc[4] && auto_rts_en, 2) && $past(!mc[4] && auto_rts_en) &&
      $past(auto_rts_level) == $past(auto_rts_level, 2) |-> $stable(rts_n_pin);
  endproperty
  a_auto: assert property (p_auto) else $error("request pin moved under flow control");
  property p_loop; $past(mc[4]) |-> cts_status == $past(mc[1]) && dsr_status == $past(mc[0]); endproperty
  a_loop: assert property (p_loop) else $error("loopback status wrong");
  property p_ser; rx_serial_in == $past(mc[4] ? tx_serial_out : rx_pin); endproperty
  a_ser: assert property (p_ser) else $error("serial input path wrong");
  property p_brk;
    !$past(reset) && $past(rx_push && rx_line_low_frame) |-> rx_store_en && rx_store_data == 8'h00 && rx_store_flags[2];
  endproperty
  a_brk: assert property (p_brk) else $error("break store wrong");
  c_thr: cover property (flow_threshold_wr);
  c_xon: cover property ($rose(xon_any_en));
  c_brk: cover property (rx_store_en && rx_store_flags[2]);
endmodule
bind umcls_core umcls_core_props i_props (.*);
`default_nettype wire

// ### sim/umcls_modem.sv
// Modem peer that answers the control lines and loops data back.
`timescale 1ns/1ns
`default_nettype none
module umcls_modem #(
  parameter int DLY = 1
) (
  input wire logic core_clk, rts_n_pin, dtr_n_pin, tx_pin,
  output logic cts_n_pin, dsr_n_pin, rx_pin
);
  logic [7:0] hist = 8'hFF;
  initial {cts_n_pin, dsr_n_pin, rx_pin} = 3'b111;
  // A slow peer grants clear-to-send several cycles after the request.
  always @(posedge core_clk) begin
    hist <= {hist[6:0], rts_n_pin};
    cts_n_pin <= hist[DLY-1];
    dsr_n_pin <= dtr_n_pin;
    rx_pin <= tx_pin;
  end
endmodule
`default_nettype wire
